// File: verilog/charger_status_flag_regs.sv
`timescale 1ns/1ps
module charger_status_flag_regs
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // register read port from the serial interface
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    output logic      [7:0] reg_rdata,
    // live fault and thermistor conditions
    input  wire logic       input_overvoltage_live,
    input  wire logic       battery_overcurrent_live,
    input  wire logic       battery_undervoltage_live,
    input  wire logic       therm_cold_live,
    input  wire logic       therm_cool_live,
    input  wire logic       therm_warm_live,
    input  wire logic       therm_hot_live,
    input  wire logic       therm_open_live,
    // live comparator alarms
    input  wire logic       alarm_one_live,
    input  wire logic       alarm_two_live,
    input  wire logic       alarm_three_live,
    // charger activity levels feeding the event flags
    input  wire logic       taper_active,
    input  wire logic       charge_done_active,
    input  wire logic       input_limit_active,
    input  wire logic       powerpath_mgmt_active,
    input  wire logic       input_voltage_mgmt_active,
    input  wire logic       thermal_regulation_active,
    input  wire logic       input_good
);
    import charger_flag_pkg::*;

    //------------------------------------------------------------------
    // live status views
    //------------------------------------------------------------------
    wire logic [7:0] fault_temp_status;
    wire logic [7:0] comparator_open_status;

    // fault register is purely combinational, nothing to reset
    assign fault_temp_status[OVERVOLTAGE_BIT]  =
        input_overvoltage_live;
    assign fault_temp_status[6]                = 1'b0;
    assign fault_temp_status[OVERCURRENT_BIT]  =
        battery_overcurrent_live;
    assign fault_temp_status[UNDERVOLTAGE_BIT] =
        battery_undervoltage_live;
    assign fault_temp_status[COLD_BIT]         = therm_cold_live;
    assign fault_temp_status[COOL_BIT]         = therm_cool_live;
    assign fault_temp_status[WARM_BIT]         = therm_warm_live;
    assign fault_temp_status[HOT_BIT]          = therm_hot_live;

    // comparator alarms and open thermistor; reserved bits read zero
    assign comparator_open_status[7]               = 1'b0;
    assign comparator_open_status[ALARM_ONE_BIT]   = alarm_one_live;
    assign comparator_open_status[ALARM_TWO_BIT]   = alarm_two_live;
    assign comparator_open_status[ALARM_THREE_BIT] = alarm_three_live;
    assign comparator_open_status[3:1]             = 3'h0;
    assign comparator_open_status[OPEN_BIT]        = therm_open_live;

    //------------------------------------------------------------------
    // event detection
    //------------------------------------------------------------------
    logic [EVENT_COUNT-1:0] level_prev_r;
    logic                   primed_r;
    wire logic [EVENT_COUNT-1:0] level_now;
    wire logic [EVENT_COUNT-1:0] event_hit;
    wire logic [EVENT_COUNT-1:0] flag_bits;
    wire logic                   flags_read;

    // levels packed in flag bit order
    assign level_now[TAPER_BIT]       = taper_active;
    assign level_now[DONE_BIT]        = charge_done_active;
    assign level_now[INPUT_LIMIT_BIT] = input_limit_active;
    assign level_now[POWERPATH_BIT]   = powerpath_mgmt_active;
    assign level_now[INPUT_VOLT_BIT]  = input_voltage_mgmt_active;
    assign level_now[THERMAL_BIT]     = thermal_regulation_active;
    assign level_now[GOOD_CHANGE_BIT] = input_good;

    // rising edges for the activity flags; any edge for power good.
    // primed_r masks the first cycle so power-up levels are not events.
    assign event_hit[TAPER_BIT] = primed_r
        & taper_active & ~level_prev_r[TAPER_BIT];
    assign event_hit[DONE_BIT] = primed_r
        & charge_done_active & ~level_prev_r[DONE_BIT];
    assign event_hit[INPUT_LIMIT_BIT] = primed_r
        & input_limit_active & ~level_prev_r[INPUT_LIMIT_BIT];
    assign event_hit[POWERPATH_BIT] = primed_r
        & powerpath_mgmt_active & ~level_prev_r[POWERPATH_BIT];
    assign event_hit[INPUT_VOLT_BIT] = primed_r
        & input_voltage_mgmt_active & ~level_prev_r[INPUT_VOLT_BIT];
    assign event_hit[THERMAL_BIT] = primed_r
        & thermal_regulation_active & ~level_prev_r[THERMAL_BIT];
    assign event_hit[GOOD_CHANGE_BIT] = primed_r
        & (input_good ^ level_prev_r[GOOD_CHANGE_BIT]);

    // previous levels for edge detection
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            level_prev_r <= '0;
            primed_r     <= 1'b0;
        end
        else
        begin
            level_prev_r <= level_now;
            primed_r     <= 1'b1;
        end
    end

    //------------------------------------------------------------------
    // sticky flags, cleared by a read of the flag register
    //------------------------------------------------------------------
    assign flags_read = reg_rd
        & (reg_addr == CHARGE_EVENT_FLAGS_ADDR);

    genvar g;
    generate
        for (g = 0; g < EVENT_COUNT; g = g + 1)
        begin : gen_flag
            event_flag_bit u_flag
            (
                .sys_clk     (sys_clk),
                .resetn      (resetn),
                .event_pulse (event_hit[g]),
                .clear_read  (flags_read),
                .flag_r      (flag_bits[g])
            );
        end
    endgenerate

    //------------------------------------------------------------------
    // read data
    //------------------------------------------------------------------
    wire logic [7:0] read_select;
    wire logic [7:0] reg_rdata_nxt;

    // unmapped offsets read zero; flag snapshot is taken before clear
    assign read_select =
        (reg_addr == FAULT_TEMP_STATUS_ADDR) ?
            fault_temp_status :
        (reg_addr == COMPARATOR_OPEN_STATUS_ADDR) ?
            comparator_open_status :
        (reg_addr == CHARGE_EVENT_FLAGS_ADDR) ?
            {1'b0, flag_bits} :
            READ_DATA_RESET;

    // hold the last answer between strobes by recirculation, so the
    // register still loads on every edge and needs no enable
    assign reg_rdata_nxt = reg_rd ? read_select : reg_rdata;

    // read data register
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            reg_rdata <= READ_DATA_RESET;
        else
            reg_rdata <= reg_rdata_nxt;
    end

endmodule : charger_status_flag_regs

// File: verilog/charger_flag_pkg.sv
// Behaviour
// - fault status has no reset value and shows live detector conditions.
// - fault status bit 7 reads one while input overvoltage is present.
// - status bit 5 reads one while battery overcurrent protection is active.
// - fault status bit 4 reads one while battery is below lockout level.
// - bit 2 reads one while thermistor is in the cool region.
// - bit 1 reads one while thermistor is in the warm region.
// - second status bits 6,5,4 show comparator one, two, three alarms live.
// - second status bit 0 reads one above the thermistor open threshold.
// - second status bit 7 and bits 3 to 1 are reserved, read zero.
// - event flags reset to zero; a host read of the flag register clears each flag that sees no event in that cycle.
// - flag bit 6 latches on constant-voltage taper entry until read.
// - flag bit 5 latches on charge termination until read.
// - flag bit 4 latches on input current limiting until read.
// - flag bit 3 latches on power-path management operation until read.
// - flag bit 2 latches on input-voltage management operation until read.
// - flag bit 1 latches on thermal regulation until read.
// - flag bit 0 latches on any change of input power-good status.
package charger_flag_pkg;

    //------------------------------------------------------------------
    // register offsets
    //------------------------------------------------------------------
    localparam logic [7:0] FAULT_TEMP_STATUS_ADDR      = 8'h01;
    localparam logic [7:0] COMPARATOR_OPEN_STATUS_ADDR = 8'h02;
    localparam logic [7:0] CHARGE_EVENT_FLAGS_ADDR     = 8'h03;

    //------------------------------------------------------------------
    // field positions
    //------------------------------------------------------------------
    localparam int OVERVOLTAGE_BIT  = 7;
    localparam int OVERCURRENT_BIT  = 5;
    localparam int UNDERVOLTAGE_BIT = 4;
    localparam int COLD_BIT         = 3;
    localparam int COOL_BIT         = 2;
    localparam int WARM_BIT         = 1;
    localparam int HOT_BIT          = 0;
    localparam int ALARM_ONE_BIT    = 6;
    localparam int ALARM_TWO_BIT    = 5;
    localparam int ALARM_THREE_BIT  = 4;
    localparam int OPEN_BIT         = 0;
    localparam int TAPER_BIT        = 6;
    localparam int DONE_BIT         = 5;
    localparam int INPUT_LIMIT_BIT  = 4;
    localparam int POWERPATH_BIT    = 3;
    localparam int INPUT_VOLT_BIT   = 2;
    localparam int THERMAL_BIT      = 1;
    localparam int GOOD_CHANGE_BIT  = 0;
    localparam int EVENT_COUNT      = 7;

    //------------------------------------------------------------------
    // reset values
    //------------------------------------------------------------------
    localparam logic [7:0] FLAGS_RESET     = 8'h00;
    localparam logic [7:0] READ_DATA_RESET = 8'h00;

endpackage : charger_flag_pkg

// File: verilog/event_flag_bit.sv
`timescale 1ns/1ps
// one sticky event flag, set on event, cleared by a read
module event_flag_bit
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic resetn,
    // control
    input  wire logic event_pulse,
    input  wire logic clear_read,
    // state
    output logic      flag_r
);
    import charger_flag_pkg::*;

    logic flag_nxt;

    // set wins over clear so a colliding event survives the read
    assign flag_nxt = event_pulse | (flag_r & ~clear_read);

    // sticky flag register
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            flag_r <= 1'b0;
        else
            flag_r <= flag_nxt;
    end

endmodule : event_flag_bit

// File: tb/flag_regs_sva.sv
`timescale 1ns/1ps
// watches the read port against the live and event inputs
module flag_regs_sva
(
    // clock, reset and read port
    input wire logic       sys_clk,
    input wire logic       resetn,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    // event levels
    input wire logic       taper_active,
    input wire logic       input_good,
    // live status inputs
    input wire logic       input_overvoltage_live,
    input wire logic       battery_overcurrent_live,
    input wire logic       battery_undervoltage_live,
    input wire logic       therm_cold_live,
    input wire logic       therm_cool_live,
    input wire logic       therm_warm_live,
    input wire logic       therm_hot_live,
    input wire logic       alarm_one_live,
    input wire logic       alarm_two_live,
    input wire logic       alarm_three_live,
    input wire logic       therm_open_live
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    wire flag_rd = reg_rd && reg_addr == 8'h03;
    // the good input is only watched once the design has seen one clean edge
    sequence s_taper_rise; !taper_active ##1 taper_active; endsequence
    sequence s_good_flip; resetn ##1 $changed(input_good); endsequence
    sequence s_quiet_read; flag_rd && $stable(input_good); endsequence
    sequence s_taper_on_read;
        !taper_active ##1 taper_active && flag_rd;
    endsequence
    a_status_one_map:
        assert property (reg_rd && reg_addr == 8'h01 |=> reg_rdata == $past(
        {input_overvoltage_live, 1'b0, battery_overcurrent_live,
        battery_undervoltage_live, therm_cold_live, therm_cool_live,
        therm_warm_live, therm_hot_live})) else $error("status one bad");
    a_status_two_map:
        assert property (reg_rd && reg_addr == 8'h02 |=> reg_rdata == $past(
        {1'b0, alarm_one_live, alarm_two_live, alarm_three_live, 3'b000,
        therm_open_live})) else $error("status two bad");
    a_unmapped_zero:
        assert property (reg_rd && (reg_addr == 0 || reg_addr > 3) |=>
        reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_flag_top_zero:
        assert property (flag_rd |=> !reg_rdata[7]) else $error("bit 7 set");
    a_taper_latch:
        assert property (s_taper_rise ##1 flag_rd |=> reg_rdata[6])
        else $error("taper entry lost");
    a_good_change:
        assert property (s_good_flip ##1 flag_rd |=> reg_rdata[0])
        else $error("power good change lost");
    a_read_clears:
        assert property (s_quiet_read ##1 s_quiet_read |=> !reg_rdata[0])
        else $error("flag not cleared by read");
    a_event_beats_clear:
        assert property (s_taper_on_read ##1 flag_rd |=> reg_rdata[6])
        else $error("event lost to a read");
endmodule : flag_regs_sva
bind charger_status_flag_regs flag_regs_sva flag_regs_sva_i (.sys_clk,
    .resetn, .reg_rd, .taper_active, .input_good, .reg_addr, .reg_rdata,
    .input_overvoltage_live, .battery_overcurrent_live,
    .battery_undervoltage_live, .therm_cold_live, .therm_cool_live,
    .therm_warm_live, .therm_hot_live, .alarm_one_live, .alarm_two_live,
    .alarm_three_live, .therm_open_live);

// File: tb/host_reader.sv
`timescale 1ns/1ps
// host side of the read port; rd is entered at a falling edge
module host_reader
(
    // clock and answer from the block
    input  wire logic       sys_clk,
    input  wire logic [7:0] reg_rdata,
    // read request to the block
    output logic            reg_rd,
    output logic      [7:0] reg_addr
);
    initial {reg_rd, reg_addr} = '0;
    // back-to-back calls keep the strobe high, one read per cycle
    task rd(input logic [7:0] a, output logic [7:0] d);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask : rd
    // released address must not keep looking valid
    task stop;
        reg_rd = 1'b0;
        reg_addr = ~reg_addr;
    endtask : stop
endmodule : host_reader

// File: tb/charger_status_flag_regs_tb.sv
`timescale 1ns/1ps
module charger_status_flag_regs_tb;
    logic        sys_clk, resetn, reg_rd;
    logic [7:0]  reg_addr, reg_rdata, s1, s2, d;
    logic [6:0]  act;
    logic [31:0] seed;
    int          miscompares, tests_run, cyc;
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    charger_status_flag_regs charger_status_flag_regs_i (.sys_clk, .resetn,
        .reg_rd, .reg_addr, .reg_rdata, .input_overvoltage_live(s1[7]),
        .battery_overcurrent_live(s1[5]), .battery_undervoltage_live(s1[4]),
        .therm_cold_live(s1[3]), .therm_cool_live(s1[2]),
        .therm_warm_live(s1[1]), .therm_hot_live(s1[0]),
        .therm_open_live(s2[0]), .alarm_one_live(s2[6]),
        .alarm_two_live(s2[5]), .alarm_three_live(s2[4]),
        .taper_active(act[6]), .charge_done_active(act[5]),
        .input_limit_active(act[4]), .powerpath_mgmt_active(act[3]),
        .input_voltage_mgmt_active(act[2]),
        .thermal_regulation_active(act[1]), .input_good(act[0]));
    host_reader host_reader_i (.sys_clk, .reg_rdata, .reg_rd, .reg_addr);
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    // unused and reserved bits never follow the live inputs
    function automatic logic [7:0] exp_stat(input logic [7:0] v, m);
        return v & m;
    endfunction : exp_stat
    task chk(input logic [7:0] e, g);
        tests_run++;
        if (g !== e)
        begin
            miscompares++;
            $display("CHECK FAILED read data expected %h seen %h", e, g);
        end
    endtask : chk
    task results;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    // hang guard, the whole run needs under 200 cycles
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 400)
        begin
            miscompares++;
            results();
        end
    end
    initial
    begin
        {resetn, s1, s2, act, miscompares, tests_run, cyc} = '0;
        seed = 32'h0eda_6b05;
        repeat (6) @(negedge sys_clk);
        resetn = 1'b1;
        host_reader_i.rd(8'h03, d);
        chk(8'h00, d);
        for (int i = 0; i < 40; i++)
        begin
            seed = lfsr(seed);
            {s1, s2} = seed[15:0];
            host_reader_i.rd(8'h01, d);
            chk(exp_stat(s1, 8'hbf), d);
            host_reader_i.rd(8'h02, d);
            chk(exp_stat(s2, 8'h71), d);
        end
        // unmapped offsets read as zero
        for (int a = 0; a < 256; a += 85)
        begin
            host_reader_i.rd(8'(a), d);
            chk(8'h00, d);
        end
        // each event lands on a clearing read, then is read back and cleared
        for (int i = 0; i < 7; i++)
        begin
            act[i] = 1'b1;
            host_reader_i.rd(8'h03, d);
            chk(8'h00, d);
            host_reader_i.rd(8'h03, d);
            chk(8'h01 << i, d);
            host_reader_i.rd(8'h03, d);
            chk(8'h00, d);
            act[i] = 1'b0;
            host_reader_i.rd(8'h03, d);
            host_reader_i.rd(8'h03, d);
            chk((i == 0) ? 8'h01 : 8'h00, d);
            host_reader_i.rd(8'h03, d);
        end
        host_reader_i.stop();
        repeat (3) @(negedge sys_clk);
        results();
    end
endmodule : charger_status_flag_regs_tb
